/* File: core/lpws_pkg.sv */
package lpws_pkg;

  // ----------------------------------------
  // operating states
  // ----------------------------------------
  typedef enum logic [2:0] {
    st_init_reset,
    st_init,
    st_reset,
    st_normal_request,
    st_normal,
    st_sleep_cut,
    st_sleep_kept
  } lpws_mode_e;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  // stored configuration written by the chip's register file
  typedef struct packed {
    logic can_supply;       // transceiver supply regulator
    logic aux;              // auxiliary_regulator
    logic can;              // transceiver tx/rx
    logic lin;              // lin transceivers
    logic can_wake;         // bus wake detection in low power
    logic sense_en;         // cyclic contact sensing
    logic cyc_int_en;       // cyclic interrupt keep-alive
    logic int_sup_en;       // interrupt-response supervision
    logic [1:0] on_sel;     // sense_on_time select
  } lpws_cfg_s;

  // one io pin: high_side_switch and low_side_switch
  typedef struct packed {
    logic hs;
    logic ls;
  } lpws_drive_s;

  // ----------------------------------------
  // spi command bytes
  // ----------------------------------------
  localparam logic [7:0] CMD_CH_READ = 8'h1b;
  localparam logic [7:0] CMD_REFRESH = 8'h5a;
  localparam logic [7:0] CMD_PERIOD = 8'h56;
  localparam logic [7:0] CMD_INT_READ = 8'h1c;
  localparam logic [15:0] CMD_WAKE = 16'h5c10;
  localparam int FRAME_BITS = 16;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 20;
  localparam int US_NS = 1000;
  localparam int TICK_CYC = US_NS / CLK_NS;
  localparam int ON_BASE_US = 200;
  localparam int DEGLITCH_US = 30;
  localparam int INT_PULSE_US = 100;
  localparam int RESET_US = 1000;
  localparam int US_PER_MS = 1000;
  localparam int SUP_PERIODS = 2;
  localparam int CNT_W = 20;
  localparam logic [7:0] CH_SEED = 8'h5b;
  localparam logic [3:0] PERIOD_RST = 4'he;

  // period select to microseconds
  function automatic logic [CNT_W-1:0] period_us(input logic [3:0] sel);
    int ms;
    case (sel)
      4'h0: ms = 3;
      4'h1: ms = 6;
      4'h2: ms = 10;
      4'h3: ms = 13;
      4'h4: ms = 16;
      4'h5: ms = 20;
      4'h6: ms = 24;
      4'h7: ms = 32;
      4'h8: ms = 48;
      4'h9: ms = 64;
      4'ha: ms = 96;
      4'hb: ms = 128;
      4'hc: ms = 192;
      4'hd: ms = 256;
      default: ms = 512;
    endcase
    return CNT_W'(ms * US_PER_MS);
  endfunction

endpackage

/* File: core/lpws_spi_slave.sv */
`timescale 1ns/1ps
`default_nettype none

// spi mode 0 slave, oversampled by the system clock
module lpws_spi_slave
  import lpws_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst_n,
  // pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // user side
  input wire logic [FRAME_BITS-1:0] reply,
  output logic frame_valid,
  output logic [FRAME_BITS-1:0] frame
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] sclk_s; // first stage only feeds second
  logic [1:0] cs_s;
  logic [1:0] mosi_s;
  logic sclk_d; // previous synced clock, edge finder
  logic cs_d;
  logic [FRAME_BITS-1:0] rx; // receive shift
  logic [FRAME_BITS-1:0] tx; // transmit shift
  logic [4:0] nbit; // bits taken this frame

  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      sclk_s <= '0;
      cs_s <= 2'b11;
      mosi_s <= '0;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end
    else
    begin
      sclk_s <= {sclk_s[0], sclk};
      cs_s <= {cs_s[0], cs_n};
      mosi_s <= {mosi_s[0], mosi};
      sclk_d <= sclk_s[1];
      cs_d <= cs_s[1];
    end
  end

  // ----------------------------------------
  // shifting
  // ----------------------------------------
  // reply loaded at select, so it is a snapshot of that moment
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      rx <= '0;
      tx <= '0;
      nbit <= '0;
      frame_valid <= 1'b0;
      frame <= '0;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end
    else
    begin
      frame_valid <= 1'b0;
      miso_oe <= !cs_s[1];
      if (cs_d && !cs_s[1])
      begin
        // select: load reply, msb first
        tx <= reply << 1;
        miso <= reply[FRAME_BITS-1];
        nbit <= '0;
      end
      else if (!cs_s[1] && sclk_s[1] && !sclk_d)
      begin
        rx <= {rx[FRAME_BITS-2:0], mosi_s[1]};
        nbit <= nbit + 5'd1;
      end
      else if (!cs_s[1] && !sclk_s[1] && sclk_d)
      begin
        miso <= tx[FRAME_BITS-1];
        tx <= tx << 1;
      end
      else if (!cs_d && cs_s[1])
      begin
        // frames of other length are dropped
        frame_valid <= (nbit == 5'(FRAME_BITS));
        frame <= rx;
      end
    end
  end

endmodule

`default_nettype wire

/* File: core/lpws_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - late interrupt access flagged after two periods
// - init reset: transceiver off, ground termination
// - debug entry turns transceiver supply on
// - high-side io outputs held in reset, init and normal request; cleared in init reset
// - low-side drive pin off in reset
// - low-side contact pin held through reset
// - sensing runs in both low-power states
// - dedicated timer for selected sense period
// - drive pin pulses for selected on-time
// - pulsed transistor follows pre-sleep pin state
// - any high contact during on-time wakes
// - contact level must outlast 30 us filter
// - periodic interrupt pulse in supply-kept sleep
// - missing ack: reset then normal request
// - ack is challenge read then inverted refresh
// - ack accepted anywhere within the period
// - no ack expected before first pulse
// - wake command ends cyclic interrupt operation
// - challenge changes each use, always readable
module lpws_sequencer
  import lpws_pkg::*;
#(
  parameter int TICK = TICK_CYC,
  parameter int RESET_TICKS = RESET_US
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // mode requests from the main controller
  input wire lpws_mode_e mode_req,
  input wire logic mode_req_valid,
  // stored configuration
  input wire lpws_cfg_s cfg,
  input wire logic cfg_load,
  input wire lpws_drive_s drive_cfg0,
  input wire lpws_drive_s drive_cfg1,
  // pins
  input wire logic debug_select_pin,
  input wire logic [2:0] contact_in,
  // interrupt supervision events
  input wire logic int_event,
  input wire logic wd_period_tick,
  // spi
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // state and enables
  output lpws_mode_e mode,
  output logic rst_req,
  output logic vdd_en,
  output logic can_supply_en,
  output logic aux_en,
  output logic can_tx_en,
  output logic can_rx_en,
  output logic can_wake_en,
  output logic can_term_gnd,
  output logic lin_en,
  output lpws_drive_s io0_drv,
  output lpws_drive_s io1_drv,
  // events
  output logic cyc_int_n,
  output logic sense_wake,
  output logic int_resp_late
);

  // ----------------------------------------
  // reset release and pin sync
  // ----------------------------------------
  logic [1:0] rst_q; // release chain
  logic srst_n;
  logic [1:0] dbg_s; // debug pin sync
  logic [5:0] cont_s; // two stages of three contacts
  logic [2:0] cont; // contacts, synced

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_q <= '0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign srst_n = rst_q[1];

  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      dbg_s <= '0;
      cont_s <= '0;
    end
    else
    begin
      dbg_s <= {dbg_s[0], debug_select_pin};
      cont_s <= {cont_s[2:0], contact_in};
    end
  end
  assign cont = cont_s[5:3];

  // ----------------------------------------
  // microsecond tick divider
  // ----------------------------------------
  logic [7:0] div; // cycles into current microsecond
  logic us; // one-cycle enable

  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      div <= '0;
      us <= 1'b0;
    end
    else
    begin
      us <= (div == 8'(TICK - 1));
      div <= (div == 8'(TICK - 1)) ? '0 : div + 8'd1;
    end
  end

  // ----------------------------------------
  // spi port and command decode
  // ----------------------------------------
  logic fv; // frame strobe
  logic [15:0] fr; // received frame
  logic [7:0] challenge; // current challenge_byte
  logic cmd_wake;
  logic cmd_ref;

  lpws_spi_slave u_spi (
    .sys_clk(sys_clk),
    .srst_n(srst_n),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .mosi(spi_mosi),
    .miso(spi_miso),
    .miso_oe(spi_miso_oe),
    .reply({5'h00, mode, challenge}),
    .frame_valid(fv),
    .frame(fr)
  );
  assign cmd_wake = fv && (fr == CMD_WAKE);
  assign cmd_ref = fv && (fr[15:8] == CMD_REFRESH);

  // ----------------------------------------
  // configuration store
  // ----------------------------------------
  lpws_mode_e st; // operating state
  lpws_cfg_s cq; // stored configuration
  logic [3:0] per_sel; // period select, shared timer selection
  lpws_drive_s held0; // pin states at last normal
  lpws_drive_s held1;

  // supply flag may also be set by debug entry at power-up
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      cq <= '0;
      per_sel <= PERIOD_RST;
    end
    else
    begin
      if (cfg_load)
        cq <= cfg;
      else if (st == st_init_reset && mode_req_valid && dbg_s[1])
        cq.can_supply <= 1'b1;
      if (fv && fr[15:8] == CMD_PERIOD && st == st_normal)
        per_sel <= fr[3:0];
    end
  end

  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      held0 <= '0;
      held1 <= '0;
    end
    else if (st == st_normal)
    begin
      held0 <= drive_cfg0;
      held1 <= drive_cfg1;
    end
  end

  // ----------------------------------------
  // cyclic sense engine
  // ----------------------------------------
  logic sense_run; // sensing allowed now
  logic sense_on; // drive pin pulsing
  logic [CNT_W-1:0] s_cnt; // period timer, us
  logic [CNT_W-1:0] on_cnt; // on-time timer, us
  logic [5:0] glitch; // us of continuous high contact
  logic wake_det;
  logic [CNT_W-1:0] on_len;

  assign sense_run = (st == st_sleep_cut || st == st_sleep_kept) && cq.sense_en;
  assign on_len = CNT_W'(ON_BASE_US) << cq.on_sel;

  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      s_cnt <= '0;
      on_cnt <= '0;
      sense_on <= 1'b0;
    end
    else if (!sense_run)
    begin
      s_cnt <= '0;
      on_cnt <= '0;
      sense_on <= 1'b0;
    end
    else if (us && !sense_on)
    begin
      // period end starts the pulse
      if (s_cnt >= period_us(per_sel) - CNT_W'(1))
      begin
        sense_on <= 1'b1;
        on_cnt <= '0;
      end
      else
        s_cnt <= s_cnt + CNT_W'(1);
    end
    else if (us)
    begin
      if (on_cnt >= on_len - CNT_W'(1))
      begin
        sense_on <= 1'b0;
        s_cnt <= '0;
      end
      else
        on_cnt <= on_cnt + CNT_W'(1);
    end
  end

  // filter: level must last beyond the deglitch time
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      glitch <= '0;
      wake_det <= 1'b0;
    end
    else
    begin
      wake_det <= 1'b0;
      if (!sense_on || cont == 3'b000)
        glitch <= '0;
      else if (us)
      begin
        if (glitch == 6'(DEGLITCH_US))
          wake_det <= 1'b1;
        else
          glitch <= glitch + 6'd1;
      end
    end
  end

  // ----------------------------------------
  // cyclic interrupt and acknowledge
  // ----------------------------------------
  logic cyc_run;
  logic [CNT_W-1:0] c_cnt; // period timer, us
  logic [6:0] p_cnt; // pulse width, us
  logic armed; // first pulse seen
  logic ch_read; // challenge fetched this period
  logic acked; // correct refresh this period
  logic ack_fail;

  assign cyc_run = (st == st_sleep_kept) && cq.cyc_int_en;

  function automatic logic [7:0] lfsr_step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // refresh checked at any time of the period, no window
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      c_cnt <= '0;
      p_cnt <= '0;
      cyc_int_n <= 1'b1;
      armed <= 1'b0;
      ch_read <= 1'b0;
      acked <= 1'b0;
      ack_fail <= 1'b0;
      challenge <= CH_SEED;
    end
    else
    begin
      ack_fail <= 1'b0;
      if (!cyc_run)
      begin
        c_cnt <= '0;
        cyc_int_n <= 1'b1;
        armed <= 1'b0;
        ch_read <= 1'b0;
        acked <= 1'b0;
      end
      else
      begin
        if (us && c_cnt >= period_us(per_sel) - CNT_W'(1))
        begin
          c_cnt <= '0;
          cyc_int_n <= 1'b0;
          p_cnt <= '0;
          armed <= 1'b1;
          acked <= 1'b0;
          ch_read <= 1'b0;
          ack_fail <= armed && !acked;
        end
        else if (us)
          c_cnt <= c_cnt + CNT_W'(1);
        if (us && !cyc_int_n)
        begin
          p_cnt <= p_cnt + 7'd1;
          if (p_cnt == 7'(INT_PULSE_US - 1))
            cyc_int_n <= 1'b1;
        end
        if (fv && fr[15:8] == CMD_CH_READ && armed)
          ch_read <= 1'b1;
        if (cmd_ref && armed)
        begin
          if (ch_read && fr[7:0] == ~challenge)
            acked <= 1'b1;
          else
            ack_fail <= 1'b1;
          challenge <= lfsr_step(challenge);
        end
      end
    end
  end

  // ----------------------------------------
  // interrupt-response supervision
  // ----------------------------------------
  logic int_pend; // interrupt not yet read
  logic [1:0] sup_cnt; // watchdog periods waited

  // a new event in the read cycle wins over the clear
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      int_pend <= 1'b0;
      sup_cnt <= '0;
      int_resp_late <= 1'b0;
    end
    else if (int_event && cq.int_sup_en)
    begin
      int_pend <= 1'b1;
      sup_cnt <= '0;
    end
    else if (fv && fr[15:8] == CMD_INT_READ)
    begin
      int_pend <= 1'b0;
      int_resp_late <= 1'b0;
    end
    else if (int_pend && wd_period_tick)
    begin
      sup_cnt <= sup_cnt + 2'd1;
      if (sup_cnt == 2'(SUP_PERIODS - 1))
        int_resp_late <= 1'b1;
    end
  end

  // ----------------------------------------
  // operating state
  // ----------------------------------------
  logic [CNT_W-1:0] r_cnt; // reset length, us

  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      st <= st_init_reset;
      r_cnt <= '0;
    end
    else if (ack_fail)
    begin
      st <= st_reset;
      r_cnt <= '0;
    end
    else if (mode_req_valid)
      st <= mode_req;
    else
    begin
      unique case (st)
        st_reset:
        begin
          if (us)
            r_cnt <= r_cnt + CNT_W'(1);
          if (r_cnt == CNT_W'(RESET_TICKS))
            st <= st_normal_request;
        end
        st_sleep_cut:
          if (wake_det)
          begin
            st <= st_reset;
            r_cnt <= '0;
          end
        st_sleep_kept:
          if (cmd_wake || wake_det)
            st <= st_normal_request;
        st_init_reset, st_init, st_normal_request, st_normal:
          r_cnt <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // output enables per state
  // ----------------------------------------
  logic in_hold; // reset, init or normal request
  assign in_hold = (st == st_reset || st == st_init || st == st_normal_request);

  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      mode <= st_init_reset;
      rst_req <= 1'b0;
      vdd_en <= 1'b0;
      can_supply_en <= 1'b0;
      aux_en <= 1'b0;
      can_tx_en <= 1'b0;
      can_rx_en <= 1'b0;
      can_wake_en <= 1'b0;
      can_term_gnd <= 1'b0;
      lin_en <= 1'b0;
      io0_drv <= '0;
      io1_drv <= '0;
      sense_wake <= 1'b0;
    end
    else
    begin
      mode <= st;
      rst_req <= (st == st_reset);
      sense_wake <= wake_det;
      vdd_en <= (st != st_sleep_cut);
      can_supply_en <= cq.can_supply && (in_hold || st == st_normal);
      aux_en <= (st == st_normal) && cq.aux;
      can_tx_en <= (st == st_normal) && cq.can;
      can_rx_en <= (st == st_normal) && cq.can;
      can_wake_en <= (st == st_sleep_cut || st == st_sleep_kept) && cq.can_wake;
      can_term_gnd <= (st == st_init_reset);
      lin_en <= (st == st_normal) && cq.lin;
      if (st == st_normal)
      begin
        io0_drv <= drive_cfg0;
        io1_drv <= drive_cfg1;
      end
      else if (in_hold)
      begin
        io0_drv <= '{hs: held0.hs, ls: 1'b0};
        io1_drv <= held1;
      end
      else if (sense_run)
      begin
        io0_drv <= sense_on ? held0 : '0;
        io1_drv <= held1;
      end
      else if (st == st_init_reset)
      begin
        io0_drv <= '0;
        io1_drv <= '0;
      end
      else
      begin
        io0_drv <= held0;
        io1_drv <= held1;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!srst_n);

  // outputs leave their reset values one edge after the internal release
  can_off_init_a: assert property (srst_n && (st == st_init_reset) |=>
    !can_tx_en && !can_rx_en && !can_wake_en && can_term_gnd)
    else $error("transceiver not off in init reset");
  ls0_reset_a: assert property ((st == st_reset) |=> !io0_drv.ls) else $error("drive pin low side on in reset");
  hs_hold_a: assert property (in_hold && !mode_req_valid |=> io0_drv.hs == $past(held0.hs) && io1_drv == $past(held1)) else $error("held outputs lost");
  io1_ls_hold_a: assert property ((st == st_normal_request) && held1.ls |=> io1_drv.ls) else $error("contact pin low side dropped");
  // on-time may end in the very cycle the filter fires
  wake_filter_a: assert property (wake_det |->
    $past(glitch) == 6'(DEGLITCH_US) && $past(sense_on))
    else $error("wake without filter");
  ack_reset_a: assert property (ack_fail |=> st == st_reset) else $error("missing ack without reset");
  wake_cmd_a: assert property ((st == st_sleep_kept) && cmd_wake && !ack_fail && !mode_req_valid |=> st == st_normal_request) else $error("wake command ignored");
  first_pulse_a: assert property (cyc_run && !armed && !cmd_ref |=> !ack_fail) else $error("ack expected before first pulse");
  sense_restart_a: assert property ($fell(sense_on) && sense_run |-> s_cnt == '0) else $error("sense timer not restarted");
  int_late_a: assert property ($rose(int_resp_late) |-> int_pend && sup_cnt == 2'(SUP_PERIODS)) else $error("late flag without two periods");
  on_len_a: assert property (sense_on |-> on_cnt < on_len) else $error("on-time overrun");

  sense_wake_c: cover property (wake_det);
  cyc_ack_c: cover property (cmd_ref && ch_read && fr[7:0] == ~challenge);
  ack_fail_c: cover property (ack_fail);
  int_late_c: cover property (int_resp_late);

endmodule

`default_nettype wire

/* File: verif/lpws_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// microcontroller side: spi master, mode 0
// ----------------------------------------
module lpws_spi_host (
  // pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // sclk stands still low outside frames
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // one 16-bit frame, msb first, 160 ns sclk
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rx);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      mosi = cmd[i];
      #80 sclk = 1'b1;
      rx[i] = miso;
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    // released line must not look like a held bit
    mosi = ~mosi;
    #100;
  endtask
endmodule

`default_nettype wire

/* File: verif/lpws_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none

module lpws_sequencer_test
  import lpws_pkg::*;
;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic sys_clk, rst_n, req_v, cfg_load, dbg, int_ev, wd_tick, sclk, cs_n, mosi, miso;
  lpws_mode_e req, mode;
  lpws_cfg_s cfg;
  lpws_drive_s d0, d1, io0, io1;
  logic [2:0] contact;
  logic vdd_en, can_sup, aux_en, can_tx, term_gnd, cyc_int_n, late, rst_req, s_wake;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  logic [15:0] rx;
  logic [7:0] ch;

  // short counts keep the run small
  lpws_sequencer #(.TICK(2), .RESET_TICKS(5)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .mode_req(req), .mode_req_valid(req_v), .cfg(cfg), .cfg_load(cfg_load),
    .drive_cfg0(d0), .drive_cfg1(d1), .debug_select_pin(dbg), .contact_in(contact),
    .int_event(int_ev), .wd_period_tick(wd_tick), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(), .mode(mode), .rst_req(rst_req),
    .vdd_en(vdd_en), .can_supply_en(can_sup), .aux_en(aux_en), .can_tx_en(can_tx),
    .can_rx_en(), .can_wake_en(), .can_term_gnd(term_gnd), .lin_en(), .io0_drv(io0),
    .io1_drv(io1), .cyc_int_n(cyc_int_n), .sense_wake(s_wake), .int_resp_late(late));
  lpws_spi_host host_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      error_cnt++;
      close_out();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic go(input lpws_mode_e m);
    req = m;
    req_v = 1'b1;
    step(1);
    req_v = 1'b0;
    step(3);
  endtask
  task automatic spi(input logic [15:0] c);
    host_u.xfer(c, rx);
    step(1);
  endtask
  // bounded wait, then compare the state
  task automatic expect_mode(input lpws_mode_e m, input int lim);
    n = 0;
    while (mode !== m && n < lim)
    begin
      step(1);
      n++;
    end
    chk(mode === m, "mode");
  endtask
  task automatic wait_pulse();
    n = 0;
    while (cyc_int_n !== 1'b1 && n < 7000)
    begin
      step(1);
      n++;
    end
    while (cyc_int_n !== 1'b0 && n < 7000)
    begin
      step(1);
      n++;
    end
  endtask
  task automatic load(input lpws_cfg_s c);
    cfg = c;
    cfg_load = 1'b1;
    step(1);
    cfg_load = 1'b0;
  endtask
  task automatic close_out();
    $display("error_cnt=%0d tests_run=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_init();
    step(3);
    rst_n = 1'b1;
    step(3);
    chk(mode === st_init_reset && term_gnd === 1'b1 && can_tx === 1'b0, "init");
    chk(vdd_en === 1'b1 && cyc_int_n === 1'b1, "init out");
    dbg = 1'b1;
    step(3);
    go(st_init);
    chk(can_sup === 1'b1, "debug supply");
    dbg = 1'b0;
    $display("test init done");
  endtask

  task automatic t_io();
    load('{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 2'b00});
    d0 = 2'b10;
    d1 = 2'b01;
    go(st_normal);
    chk(io0 === 2'b10 && io1 === 2'b01 && aux_en === 1'b1 && can_tx === 1'b1, "normal");
    go(st_reset);
    chk(io0 === 2'b10 && io1 === 2'b01, "held in reset");
    go(st_normal);
    d0 = 2'b01;
    go(st_reset);
    chk(io0 === 2'b00, "low side off");
    go(st_normal);
    chk(io0 === 2'b01, "low side back");
    $display("test io done");
  endtask

  task automatic t_cyc();
    spi(16'h5600);
    go(st_sleep_kept);
    chk(can_tx === 1'b0, "sleep enables");
    wait_pulse();
    chk(n > 5800 && n < 7000 && mode === st_sleep_kept, "first pulse");
    spi(16'h1b00);
    ch = rx[7:0];
    spi({8'h5a, ~ch});
    wait_pulse();
    chk(n < 7000 && mode === st_sleep_kept, "kept");
    // pulse is 100 us, two cycles per us here
    n = 0;
    while (cyc_int_n === 1'b0 && n < 300)
    begin
      step(1);
      n++;
    end
    chk(n > 195 && n < 205, "pulse width");
    spi(16'h1b00);
    chk(rx[7:0] !== ch, "challenge");
    spi({8'h5a, rx[7:0]});
    expect_mode(st_reset, 20);
    chk(rst_req === 1'b1, "reset out");
    expect_mode(st_normal_request, 40);
    go(st_normal);
    go(st_sleep_kept);
    spi(16'h5c10);
    expect_mode(st_normal_request, 20);
    // no acknowledge at all: reset one period after the first pulse
    go(st_normal);
    go(st_sleep_kept);
    wait_pulse();
    expect_mode(st_reset, 6500);
    chk(n > 5800, "missing ack");
    $display("test cyclic int done");
  endtask

  task automatic t_sense();
    load('{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2'b00});
    d0 = 2'b10;
    go(st_normal);
    go(st_sleep_cut);
    n = 0;
    while (io0.hs !== 1'b1 && n < 7000)
    begin
      step(1);
      n++;
    end
    // a 20 us glitch must not wake
    contact = 3'b010;
    n = 0;
    while (io0.hs === 1'b1 && n < 1000)
    begin
      if (n == 40)
        contact = 3'b000;
      step(1);
      n++;
    end
    chk(n >= 398 && n <= 402, "on time");
    chk(mode === st_sleep_cut, "glitch");
    chk(vdd_en === 1'b0, "supply cut");
    n = 0;
    while (io0.hs !== 1'b1 && n < 6500)
    begin
      step(1);
      n++;
    end
    chk(n < 6500, "next period");
    contact = 3'b100;
    // wake pulse stands one cycle, so poll every cycle
    n = 0;
    while (s_wake !== 1'b1 && n < 200)
    begin
      step(1);
      n++;
    end
    chk(s_wake === 1'b1 && n >= 62, "filtered wake");
    expect_mode(st_reset, 20);
    contact = 3'b000;
    $display("test sense done");
  endtask

  task automatic t_sup();
    int_ev = 1'b1;
    step(1);
    int_ev = 1'b0;
    repeat (2)
    begin
      chk(late === 1'b0, "early");
      wd_tick = 1'b1;
      step(1);
      wd_tick = 1'b0;
      step(2);
    end
    chk(late === 1'b1, "late");
    spi(16'h1c00);
    step(3);
    chk(late === 1'b0, "cleared");
    $display("test supervision done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {rst_n, req_v, cfg_load, dbg, int_ev, wd_tick} = '0;
    req = st_init_reset;
    cfg = '0;
    d0 = '0;
    d1 = '0;
    contact = '0;
    t_init();
    t_io();
    t_cyc();
    t_sense();
    t_sup();
    close_out();
  end
endmodule

`default_nettype wire
